// ### rtl/parallel_serial_pin_mux.sv
// How it works
// - Three writable inhibit banks switch each pull; test reset pulldown has none.
// - Without core supply all pulls are off and bus holders are on.
// - Slew register picks fast or slow edges for the debug clock pin only.
// - Only the bus selection register decides pin ownership.
// - Parallel mode 000 gives all 21 pins to the display controller.
// - Mode 001 carries SPI, general io 12-17, audio two and UART.
// - Mode 010 keeps display low half, general io on data 8-15.
// - Mode 011 keeps display, SPI on data 8-11, audio three on 12-15.
// - Modes 100/101 keep display, UART high, audio two or SPI in between.
// - Mode 110 is mode 001 with audio three on data 12-15.
// - Data pins 2-15 have inhibit bits in bank three; others none.
// - Serial port one: 00 card, 01 audio one plus io 10-11, 10 io 6-11.
// - Each serial port one pin has its own bank one inhibit bit.
// - Serial port one mode decodes independently of parallel mode.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module parallel_serial_pin_mux (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_supply,
  output logic debug_clock_slow,
  output logic [15:0] pull_en_one,
  output logic [15:0] pull_en_two,
  output logic [15:0] pull_en_three,
  output logic trst_pulldown_en,
  output logic bus_holder_en,
  input wire logic [20:0] disp_o,
  input wire logic [20:0] disp_oe,
  output logic [20:0] disp_i,
  input wire logic [6:0] spi_o,
  input wire logic [6:0] spi_oe,
  output logic [6:0] spi_i,
  input wire logic [3:0] uart_o,
  input wire logic [3:0] uart_oe,
  output logic [3:0] uart_i,
  input wire logic [3:0] aud1_o,
  input wire logic [3:0] aud1_oe,
  output logic [3:0] aud1_i,
  input wire logic [3:0] aud2_o,
  input wire logic [3:0] aud2_oe,
  output logic [3:0] aud2_i,
  input wire logic [3:0] aud3_o,
  input wire logic [3:0] aud3_oe,
  output logic [3:0] aud3_i,
  input wire logic [5:0] card_o,
  input wire logic [5:0] card_oe,
  output logic [5:0] card_i,
  input wire logic [31:0] gp_o,
  input wire logic [31:0] gp_oe,
  output logic [31:0] gp_i,
  input wire logic [20:0] pp_pin_i,
  output pin_mux_pkg::pp_drive_s pp_pads,
  input wire logic [5:0] sp1_pin_i,
  output pin_mux_pkg::sp1_drive_s sp1_pads
);
  // ==========
  // Pin synchronisers
  logic [20:0] pp_s1_q, pp_s2_q;
  logic [5:0] sp_s1_q, sp_s2_q;
  logic core_s1_q, core_s2_q;
  always_ff @(posedge ref_clk)
  begin
    pp_s1_q <= pp_pin_i;
    pp_s2_q <= pp_s1_q;
    sp_s1_q <= sp1_pin_i;
    sp_s2_q <= sp_s1_q;
    core_s1_q <= core_supply;
    core_s2_q <= core_s1_q;
  end

  // ==========
  // Registers and APB slave
  logic [15:0] slew_q, slew_d, bank1_q, bank1_d, bank2_q, bank2_d;
  logic [15:0] bank3_q, bank3_d, bus_sel_q, bus_sel_d, rd_data;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, hit, wr;
  logic [13:0] idx;
  always_comb
  begin
    idx = paddr[15:2];
    hit = 1'b1;
    case (idx)
      pin_mux_pkg::SLEW_IDX: rd_data = slew_q;
      pin_mux_pkg::BANK1_IDX: rd_data = bank1_q;
      pin_mux_pkg::BANK2_IDX: rd_data = bank2_q;
      pin_mux_pkg::BANK3_IDX: rd_data = bank3_q;
      pin_mux_pkg::BUS_SEL_IDX: rd_data = bus_sel_q;
      default:
      begin
        rd_data = 16'h0000;
        hit = 1'b0;
      end
    endcase
    wr = psel & penable & pready_q & pwrite & hit;
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~hit;
    prdata_d = pready_d ? {16'h0000, rd_data} : prdata_q;
    slew_d = slew_q;
    bank1_d = bank1_q;
    bank2_d = bank2_q;
    bank3_d = bank3_q;
    bus_sel_d = bus_sel_q;
    if (wr)
    begin
      case (idx)
        pin_mux_pkg::SLEW_IDX: slew_d = pwdata[15:0] & pin_mux_pkg::SLEW_WMASK;
        pin_mux_pkg::BANK1_IDX: bank1_d = pwdata[15:0];
        pin_mux_pkg::BANK2_IDX: bank2_d = pwdata[15:0];
        pin_mux_pkg::BANK3_IDX: bank3_d = pwdata[15:0] & pin_mux_pkg::BANK3_WMASK;
        pin_mux_pkg::BUS_SEL_IDX: bus_sel_d = pwdata[15:0] & pin_mux_pkg::BUS_SEL_WMASK;
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      slew_q <= pin_mux_pkg::REG_RESET;
      bank1_q <= pin_mux_pkg::REG_RESET;
      bank2_q <= pin_mux_pkg::REG_RESET;
      bank3_q <= pin_mux_pkg::REG_RESET;
      bus_sel_q <= pin_mux_pkg::REG_RESET;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      slew_q <= slew_d;
      bank1_q <= bank1_d;
      bank2_q <= bank2_d;
      bank3_q <= bank3_d;
      bus_sel_q <= bus_sel_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========
  // Pin routing
  pin_mux_pkg::pp_mode_e pp_mode;
  pin_mux_pkg::sp1_mode_e sp1_mode;
  pin_mux_pkg::pp_drive_s pp_d, pp_q;
  pin_mux_pkg::sp1_drive_s sp_d, sp_q;
  logic [20:0] own, disp_d, disp_q;
  logic [6:0] spi_d, spi_q;
  logic [3:0] uart_d, uart_q, a1_d, a1_q, a2_d, a2_q, a3_d, a3_q;
  logic [5:0] card_d, card_q;
  logic [31:0] gp_d, gp_q;
  logic [15:0] pe1_d, pe1_q, pe2_d, pe2_q, pe3_d, pe3_q;
  logic slow_d, slow_q, trst_d, trst_q, hold_d, hold_q;
  always_comb
  begin
    pp_mode = pin_mux_pkg::pp_mode_e'(bus_sel_q[pin_mux_pkg::PP_MODE_LSB +: 3]);
    sp1_mode = pin_mux_pkg::sp1_mode_e'(bus_sel_q[pin_mux_pkg::SP1_MODE_LSB +: 2]);
    pp_d.o = disp_o;
    pp_d.oe = disp_oe;
    own = '1;
    spi_d = '0;
    uart_d = '0;
    a1_d = '0;
    a2_d = '0;
    a3_d = '0;
    card_d = '0;
    gp_d = '0;
    sp_d = '0;
    case (pp_mode)
      pin_mux_pkg::PP_DISPLAY: ;
      pin_mux_pkg::PP_SPI_GP_AUD2_UART, pin_mux_pkg::PP_SPI_GP_AUD2_AUD3:
      begin
        own = '0;
        pp_d.o[6:0] = spi_o;
        pp_d.oe[6:0] = spi_oe;
        spi_d = pp_s2_q[6:0];
        pp_d.o[12:7] = gp_o[17:12];
        pp_d.oe[12:7] = gp_oe[17:12];
        gp_d[17:12] = pp_s2_q[12:7];
        pp_d.o[16:13] = aud2_o;
        pp_d.oe[16:13] = aud2_oe;
        a2_d = pp_s2_q[16:13];
        if (pp_mode == pin_mux_pkg::PP_SPI_GP_AUD2_UART)
        begin
          pp_d.o[20:17] = uart_o;
          pp_d.oe[20:17] = uart_oe;
          uart_d = pp_s2_q[20:17];
        end
        else
        begin
          pp_d.o[20:17] = aud3_o;
          pp_d.oe[20:17] = aud3_oe;
          a3_d = pp_s2_q[20:17];
        end
      end
      pin_mux_pkg::PP_DISP_GP:
      begin
        own[20:13] = '0;
        pp_d.o[20:13] = {gp_o[31:27], gp_o[20:18]};
        pp_d.oe[20:13] = {gp_oe[31:27], gp_oe[20:18]};
        gp_d[20:18] = pp_s2_q[15:13];
        gp_d[31:27] = pp_s2_q[20:16];
      end
      pin_mux_pkg::PP_DISP_SPI_AUD3, pin_mux_pkg::PP_DISP_SPI_UART:
      begin
        own[20:13] = '0;
        pp_d.o[16:13] = {spi_o[6:5], spi_o[1:0]};
        pp_d.oe[16:13] = {spi_oe[6:5], spi_oe[1:0]};
        spi_d[1:0] = pp_s2_q[14:13];
        spi_d[6:5] = pp_s2_q[16:15];
        if (pp_mode == pin_mux_pkg::PP_DISP_SPI_AUD3)
        begin
          pp_d.o[20:17] = aud3_o;
          pp_d.oe[20:17] = aud3_oe;
          a3_d = pp_s2_q[20:17];
        end
        else
        begin
          pp_d.o[20:17] = uart_o;
          pp_d.oe[20:17] = uart_oe;
          uart_d = pp_s2_q[20:17];
        end
      end
      pin_mux_pkg::PP_DISP_AUD2_UART:
      begin
        own[20:13] = '0;
        pp_d.o[20:13] = {uart_o, aud2_o};
        pp_d.oe[20:13] = {uart_oe, aud2_oe};
        a2_d = pp_s2_q[16:13];
        uart_d = pp_s2_q[20:17];
      end
      default:
      begin
        own = '0;
        pp_d = '0;
      end
    endcase
    disp_d = pp_s2_q & own;
    case (sp1_mode)
      pin_mux_pkg::SP1_CARD:
      begin
        sp_d.o = card_o;
        sp_d.oe = card_oe;
        card_d = sp_s2_q;
      end
      pin_mux_pkg::SP1_AUD1_GP:
      begin
        sp_d.o = {gp_o[11:10], aud1_o[2], aud1_o[3], aud1_o[1:0]};
        sp_d.oe = {gp_oe[11:10], aud1_oe[2], aud1_oe[3], aud1_oe[1:0]};
        a1_d = {sp_s2_q[2], sp_s2_q[3], sp_s2_q[1:0]};
        gp_d[11:10] = sp_s2_q[5:4];
      end
      pin_mux_pkg::SP1_GP:
      begin
        sp_d.o = gp_o[11:6];
        sp_d.oe = gp_oe[11:6];
        gp_d[11:6] = sp_s2_q;
      end
      default: ;
    endcase
    // core supply loss forces pulls off
    pe1_d = core_s2_q ? ~bank1_q : '0;
    pe2_d = core_s2_q ? ~bank2_q : '0;
    pe3_d = core_s2_q ? (~bank3_q & pin_mux_pkg::BANK3_WMASK) : '0;
    trst_d = core_s2_q;
    hold_d = ~core_s2_q;
    slow_d = slew_q[pin_mux_pkg::SLEW_SLOW_BIT];
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pp_q <= '0;
      sp_q <= '0;
      disp_q <= '0;
      spi_q <= '0;
      uart_q <= '0;
      a1_q <= '0;
      a2_q <= '0;
      a3_q <= '0;
      card_q <= '0;
      gp_q <= '0;
      pe1_q <= '0;
      pe2_q <= '0;
      pe3_q <= '0;
      trst_q <= 1'b0;
      hold_q <= 1'b1;
      slow_q <= 1'b0;
    end
    else
    begin
      pp_q <= pp_d;
      sp_q <= sp_d;
      disp_q <= disp_d;
      spi_q <= spi_d;
      uart_q <= uart_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
      a3_q <= a3_d;
      card_q <= card_d;
      gp_q <= gp_d;
      pe1_q <= pe1_d;
      pe2_q <= pe2_d;
      pe3_q <= pe3_d;
      trst_q <= trst_d;
      hold_q <= hold_d;
      slow_q <= slow_d;
    end
  end
  assign pp_pads = pp_q;
  assign sp1_pads = sp_q;
  assign disp_i = disp_q;
  assign spi_i = spi_q;
  assign uart_i = uart_q;
  assign aud1_i = a1_q;
  assign aud2_i = a2_q;
  assign aud3_i = a3_q;
  assign card_i = card_q;
  assign gp_i = gp_q;
  assign pull_en_one = pe1_q;
  assign pull_en_two = pe2_q;
  assign pull_en_three = pe3_q;
  assign trst_pulldown_en = trst_q;
  assign bus_holder_en = hold_q;
  assign debug_clock_slow = slow_q;

  // ==========
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence s_core_lost;
    !core_s2_q;
  endsequence
  sequence s_bus_wr(logic [13:0] i);
    psel && penable && pready_q && pwrite && paddr[15:2] == i;
  endsequence
  property p_core_off;
    s_core_lost |=> pe1_q == '0 && pe2_q == '0 && pe3_q == '0 && hold_q && !trst_q;
  endproperty
  a_core_off: assert property (p_core_off) else $error("pull left on without core");
  property p_bank_two;
    s_bus_wr(pin_mux_pkg::BANK2_IDX) ##1 core_s2_q |=> pe2_q == ~$past(pwdata[15:0], 2);
  endproperty
  a_bank_two: assert property (p_bank_two) else $error("bank two write not applied");
  property p_bank3_low;
    pe3_q[1:0] == 2'h0 && bank3_q[1:0] == 2'h0;
  endproperty
  a_bank3_low: assert property (p_bank3_low) else $error("data 0-1 got a bit");
  property p_slew;
    s_bus_wr(pin_mux_pkg::SLEW_IDX) |=> ##1 slow_q == $past(pwdata[0], 2);
  endproperty
  a_slew: assert property (p_slew) else $error("slew select not applied");
  property p_mode0;
    !srst && pp_mode == pin_mux_pkg::PP_DISPLAY |=> pp_q.oe == $past(disp_oe) && spi_q == '0;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 000 not all display");
  property p_mode1;
    pp_mode == pin_mux_pkg::PP_SPI_GP_AUD2_UART |=> pp_q.o[6:0] == $past(spi_o)
      && pp_q.o[20:17] == $past(uart_o) && disp_q == '0;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 001 routing wrong");
  property p_mode6;
    pp_mode == pin_mux_pkg::PP_SPI_GP_AUD2_AUD3 |=> pp_q.oe[20:17] == $past(aud3_oe)
      && uart_q == '0;
  endproperty
  a_mode6: assert property (p_mode6) else $error("mode 110 routing wrong");
  property p_mode4;
    pp_mode == pin_mux_pkg::PP_DISP_AUD2_UART |=> pp_q.o[12:0] == $past(disp_o[12:0])
      && a2_q == $past(pp_s2_q[16:13]);
  endproperty
  a_mode4: assert property (p_mode4) else $error("mode 100 routing wrong");
  property p_sp1_gp;
    sp1_mode == pin_mux_pkg::SP1_GP |=> sp_q.o == $past(gp_o[11:6]) && card_q == '0;
  endproperty
  a_sp1_gp: assert property (p_sp1_gp) else $error("serial mode 10 wrong");
  property p_idle_in;
    pp_mode == pin_mux_pkg::PP_DISP_GP |=> spi_q == '0 && uart_q == '0 && a2_q == '0
      && a3_q == '0 && disp_q[20:13] == '0;
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("unselected input not idle");
endmodule
`default_nettype wire

// ### rtl/pin_mux_pkg.sv
package pin_mux_pkg;
  // ==========
  // Register map (word index, byte address is four times it)
  localparam logic [13:0] SLEW_IDX = 14'h1C16;
  localparam logic [13:0] BANK1_IDX = 14'h1C17;
  localparam logic [13:0] BANK2_IDX = 14'h1C18;
  localparam logic [13:0] BANK3_IDX = 14'h1C19;
  localparam logic [13:0] BUS_SEL_IDX = 14'h1C1A;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] SLEW_WMASK = 16'h0001;
  localparam logic [15:0] BANK3_WMASK = 16'hFFFC;
  localparam logic [15:0] BUS_SEL_WMASK = 16'h7C00;
  // ==========
  // Field positions
  localparam int SLEW_SLOW_BIT = 0;
  localparam int PP_MODE_LSB = 12;
  localparam int SP1_MODE_LSB = 10;
  localparam int PP_PINS = 21;
  localparam int SP1_PINS = 6;
  // ==========
  // Modes
  typedef enum logic [2:0] {
    PP_DISPLAY = 3'h0,
    PP_SPI_GP_AUD2_UART = 3'h1,
    PP_DISP_GP = 3'h2,
    PP_DISP_SPI_AUD3 = 3'h3,
    PP_DISP_AUD2_UART = 3'h4,
    PP_DISP_SPI_UART = 3'h5,
    PP_SPI_GP_AUD2_AUD3 = 3'h6,
    PP_RESERVED = 3'h7
  } pp_mode_e;
  typedef enum logic [1:0] {
    SP1_CARD = 2'h0,
    SP1_AUD1_GP = 2'h1,
    SP1_GP = 2'h2,
    SP1_RESERVED = 2'h3
  } sp1_mode_e;
  // ==========
  // Pin drive groups
  typedef struct packed {
    logic [PP_PINS-1:0] o;
    logic [PP_PINS-1:0] oe;
  } pp_drive_s;
  typedef struct packed {
    logic [SP1_PINS-1:0] o;
    logic [SP1_PINS-1:0] oe;
  } sp1_drive_s;
endpackage

// ### sim/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic flip,
  input wire logic prst,
  output logic [20:0] disp_o,
  output logic [20:0] disp_oe,
  output logic [6:0] spi_o,
  output logic [6:0] spi_oe,
  output logic [3:0] uart_o,
  output logic [3:0] uart_oe,
  output logic [3:0] aud1_o,
  output logic [3:0] aud1_oe,
  output logic [3:0] aud2_o,
  output logic [3:0] aud2_oe,
  output logic [3:0] aud3_o,
  output logic [3:0] aud3_oe,
  output logic [5:0] card_o,
  output logic [5:0] card_oe,
  output logic [31:0] gp_o,
  output logic [31:0] gp_oe,
  output logic [20:0] pp_pin_i,
  output logic [5:0] sp1_pin_i
);
  // ==========
  // Peripheral and pad patterns
  logic [31:0] k;
  assign k = prst ? 32'h0 : {32{flip}};
  assign disp_o = 21'h0A5C3E ^ k[20:0];
  assign disp_oe = 21'h1F0F33 ^ k[20:0];
  assign spi_o = 7'h2D ^ k[6:0];
  assign spi_oe = 7'h56 ^ k[6:0];
  assign uart_o = 4'h9 ^ k[3:0];
  assign uart_oe = 4'h6 ^ k[3:0];
  assign aud1_o = 4'hB ^ k[3:0];
  assign aud1_oe = 4'h4 ^ k[3:0];
  assign aud2_o = 4'h3 ^ k[3:0];
  assign aud2_oe = 4'hE ^ k[3:0];
  assign aud3_o = 4'hD ^ k[3:0];
  assign aud3_oe = 4'h1 ^ k[3:0];
  assign card_o = 6'h2B ^ k[5:0];
  assign card_oe = 6'h1A ^ k[5:0];
  assign gp_o = 32'hC3A5_96F0 ^ k;
  assign gp_oe = 32'h5A0F_3C69 ^ k;
  assign pp_pin_i = 21'h13579B ^ k[20:0];
  assign sp1_pin_i = 6'h25 ^ k[5:0];
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic core_supply = 1'b1;
  logic flip = 1'b0;
  logic prst = 1'b0;
  logic [31:0] prdata, gp_o, gp_oe, gp_i, rd;
  logic pready, pslverr, debug_clock_slow, trst_pulldown_en, bus_holder_en, er;
  logic [15:0] pull_en_one, pull_en_two, pull_en_three;
  logic [20:0] disp_o, disp_oe, disp_i, pp_pin_i;
  logic [6:0] spi_o, spi_oe, spi_i;
  logic [3:0] uart_o, uart_oe, aud1_o, aud1_oe, aud2_o, aud2_oe, aud3_o, aud3_oe;
  logic [3:0] uart_i, aud1_i, aud2_i, aud3_i;
  logic [5:0] card_o, card_oe, card_i, sp1_pin_i;
  pin_mux_pkg::pp_drive_s pp_pads;
  pin_mux_pkg::sp1_drive_s sp1_pads;
  int n_errors = 0;
  int n_checks = 0;
  logic [13:0] regs [5] = '{pin_mux_pkg::SLEW_IDX, pin_mux_pkg::BANK1_IDX,
    pin_mux_pkg::BANK2_IDX, pin_mux_pkg::BANK3_IDX, pin_mux_pkg::BUS_SEL_IDX};
  logic [15:0] mk [4] = '{pin_mux_pkg::SLEW_WMASK, 16'hFFFF, 16'hFFFF,
    pin_mux_pkg::BANK3_WMASK};

  always #5 ref_clk = ~ref_clk;

  periph_model i_model (.flip, .prst, .disp_o, .disp_oe, .spi_o, .spi_oe, .uart_o,
    .uart_oe, .aud1_o, .aud1_oe, .aud2_o, .aud2_oe, .aud3_o, .aud3_oe, .card_o,
    .card_oe, .gp_o, .gp_oe, .pp_pin_i, .sp1_pin_i);

  parallel_serial_pin_mux i_dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_supply, .debug_clock_slow,
    .pull_en_one, .pull_en_two, .pull_en_three, .trst_pulldown_en, .bus_holder_en,
    .disp_o, .disp_oe, .disp_i, .spi_o, .spi_oe, .spi_i, .uart_o, .uart_oe,
    .uart_i, .aud1_o, .aud1_oe, .aud1_i, .aud2_o, .aud2_oe, .aud2_i, .aud3_o,
    .aud3_oe, .aud3_i, .card_o, .card_oe, .card_i, .gp_o, .gp_oe, .gp_i,
    .pp_pin_i, .pp_pads, .sp1_pin_i, .sp1_pads);

  // ==========
  // Expected routing
  function automatic logic [20:0] pp_map(logic [2:0] m, logic [20:0] d, logic [6:0] s,
    logic [3:0] u, logic [3:0] a2, logic [3:0] a3, logic [31:0] g);
    case (m)
      3'h1, 3'h6: return {m[2] ? a3 : u, a2, g[17:12], s};
      3'h2: return {g[31:27], g[20:18], d[12:0]};
      3'h3: return {a3, s[6], s[5], s[1], s[0], d[12:0]};
      3'h4: return {u, a2, d[12:0]};
      3'h5: return {u, s[6], s[5], s[1], s[0], d[12:0]};
      3'h7: return 21'h0;
      default: return d;
    endcase
  endfunction

  function automatic logic [5:0] sp_map(logic [1:0] m, logic [5:0] c, logic [3:0] a,
    logic [31:0] g);
    case (m)
      2'h0: return c;
      2'h1: return {g[11:10], a[2], a[3], a[1], a[0]};
      2'h2: return g[11:6];
      default: return 6'h0;
    endcase
  endfunction

  function automatic logic [54:0] in_map(logic [2:0] m, logic [1:0] sm, logic [20:0] p,
    logic [5:0] q);
    logic [31:0] g;
    logic [6:0] s;
    logic [3:0] u, a1, a2, a3;
    {g, a1, a2, a3, u, s} = '0;
    case (m)
      3'h1, 3'h6:
      begin
        {a2, g[17:12], s} = p[16:0];
        if (m[2])
          a3 = p[20:17];
        else
          u = p[20:17];
      end
      3'h2: {g[31:27], g[20:18]} = p[20:13];
      3'h3, 3'h5:
      begin
        {s[6], s[5], s[1], s[0]} = p[16:13];
        if (m[1])
          a3 = p[20:17];
        else
          u = p[20:17];
      end
      3'h4: {u, a2} = p[20:13];
      default: ;
    endcase
    case (sm)
      2'h1: {g[11:10], a1[2], a1[3], a1[1], a1[0]} = q;
      2'h2: g[11:6] = q;
      default: ;
    endcase
    return {g, a1, a2, a3, u, s};
  endfunction

  // ==========
  // Bus and checking
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1);
    chk("wait_states", 32'h2, n); // Access
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset_val", 32'h0, rd); // Reset
    end
    chk("pull3_rst", 32'hFFFC, {16'h0, pull_en_three}); // Bank three
    chk("trst_holder", 32'h2, {30'h0, trst_pulldown_en, bus_holder_en}); // Power
    chk("pads_rst", disp_o, pp_pads.o); // Display
  endtask

  task automatic t_regs();
    logic [31:0] wd;
    for (int i = 0; i < 4; i++)
    begin
      wd = (i == 0) ? 32'hFFFF_A5C1 : 32'hFFFF_A5C0;
      apb(1'b1, regs[i], wd); // Slew and inhibit banks
      apb(1'b0, regs[i], 32'h0);
      chk("reg_rd", {16'h0, wd[15:0] & mk[i]}, rd); // Readback
    end
    wt(5);
    chk("slow", 32'h1, {31'h0, debug_clock_slow}); // Slew
    chk("pull1", 32'h5A3F, {16'h0, pull_en_one}); // Bank one
    chk("pull2", 32'h5A3F, {16'h0, pull_en_two}); // Bank two
    chk("pull3", 32'h5A3C, {16'h0, pull_en_three}); // Bank three
    chk("pads_kept", disp_oe, pp_pads.oe); // Owner
    apb(1'b0, pin_mux_pkg::BUS_SEL_IDX + 14'h1, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er}); // Refusal
    chk("unmapped_rd", 32'h0, rd); // Refusal
  endtask

  task automatic t_core();
    core_supply <= 1'b0;
    wt(6);
    chk("pulls_off", 32'h0, {pull_en_one, pull_en_two | pull_en_three}); // Off
    chk("holder_on", 32'h1, {30'h0, trst_pulldown_en, bus_holder_en}); // Off
    core_supply <= 1'b1;
    wt(6);
    chk("pull3_back", 32'h5A3C, {16'h0, pull_en_three}); // Back on
    chk("holder_off", 32'h2, {30'h0, trst_pulldown_en, bus_holder_en}); // Back on
  endtask

  task automatic t_modes();
    logic [1:0] sp;
    logic [31:0] v;
    logic [54:0] e;
    for (int m = 0; m < 7; m++)
    begin
      sp = 2'(m % 3);
      v = {17'h0, m[2:0], sp, 10'h0};
      apb(1'b1, pin_mux_pkg::BUS_SEL_IDX, v);
      apb(1'b0, pin_mux_pkg::BUS_SEL_IDX, 32'h0);
      chk("bus_sel", v, rd); // Fields
      prst <= 1'b1;
      wt(1);
      prst <= 1'b0;
      for (int f = 0; f < 2; f++)
      begin
        flip <= f[0];
        wt(6);
        chk("pp_o", pp_map(m[2:0], disp_o, spi_o, uart_o, aud2_o, aud3_o, gp_o),
          pp_pads.o); // Modes
        chk("pp_oe", pp_map(m[2:0], disp_oe, spi_oe, uart_oe, aud2_oe, aud3_oe, gp_oe),
          pp_pads.oe); // Enables
        chk("sp_o", sp_map(sp, card_o, aud1_o, gp_o), sp1_pads.o); // Serial
        chk("sp_oe", sp_map(sp, card_oe, aud1_oe, gp_oe), sp1_pads.oe); // Serial
        chk("disp_i", pp_pin_i & pp_map(m[2:0], '1, '0, '0, '0, '0, '0),
          disp_i); // Inputs
        chk("card_i", sp1_pin_i & sp_map(sp, '1, '0, '0), card_i); // Inputs
        e = in_map(m[2:0], sp, pp_pin_i, sp1_pin_i);
        chk("spi_i", e[6:0], spi_i); // Inputs
        chk("uart_i", e[10:7], uart_i); // Inputs
        chk("aud3_i", e[14:11], aud3_i); // Inputs
        chk("aud2_i", e[18:15], aud2_i); // Inputs
        chk("aud1_i", e[22:19], aud1_i); // Inputs
        chk("gp_i", e[54:23], gp_i); // Inputs
      end
    end
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    wt(5);
    t_reset();
    t_regs();
    t_core();
    t_modes();
    stop_test();
  end

  initial
  begin
    wt(20000);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
